// ---- hw/pixel_pll_regs_pkg.sv ----
// Purpose: Constants for the pixel PLL control register bank
// Assumes: 8-bit registers, 4-bit register index
// Notes:   Reset values and write masks are indexed by register index
package pixel_pll_regs_pkg;

  // ****************************************
  // Bus geometry
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int NUM_RW = 9;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] IDX_INPUT_CONTROL  = 4'h0;
  localparam logic [3:0] IDX_LOOP_CONTROL   = 4'h1;
  localparam logic [3:0] IDX_FDIV_LOW       = 4'h2;
  localparam logic [3:0] IDX_FDIV_HIGH      = 4'h3;
  localparam logic [3:0] IDX_PHASE_OFFSET   = 4'h4;
  localparam logic [3:0] IDX_PHASE_CONTROL  = 4'h5;
  localparam logic [3:0] IDX_OUTPUT_ENABLES = 4'h6;
  localparam logic [3:0] IDX_OSCILLATOR     = 4'h7;
  localparam logic [3:0] IDX_INT_FILTER     = 4'h8;
  localparam logic [3:0] IDX_RESET_CMD      = 4'hA;

  // ****************************************
  // Reset values and writable bits
  // ****************************************
  localparam logic [7:0] RESET_VALS [NUM_RW] = '{
    8'h21, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] WRITE_MASKS [NUM_RW] = '{
    8'hFF, 8'h37, 8'hFF, 8'h0F, 8'h3F, 8'h03, 8'h7C, 8'hFF, 8'hFF};

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SCHMITT_HI = 7;
  localparam int SCHMITT_LO = 6;
  localparam int SRC_SEL_BIT = 5;
  localparam int LOAD_SEL_BIT = 4;
  localparam int FB_POL_BIT = 3;
  localparam int REF_POL_BIT = 2;
  localparam int DE_POL_BIT = 1;
  localparam int DET_EN_BIT = 0;
  localparam int POST_SCALE_HI = 5;
  localparam int POST_SCALE_LO = 4;
  localparam int GAIN_HI = 2;
  localparam int GAIN_LO = 0;
  localparam int FDIV_HI_HI = 3;
  localparam int OFFSET_HI = 5;
  localparam int RES_HI = 1;
  localparam int TCK_OE_BIT = 6;
  localparam int RCLK_OE_BIT = 5;
  localparam int SYNC_OE_BIT = 4;
  localparam int FUNC_SRC_BIT = 3;
  localparam int FUNC_DLY_BIT = 2;
  localparam int SHUNT_BIT = 7;
  localparam int RESIST_HI = 6;
  localparam int RESIST_LO = 4;
  localparam int CAP_HI = 3;
  localparam int CAP_LO = 1;
  localparam int FILT_TYPE_BIT = 0;

  // ****************************************
  // Reset command nibbles
  // ****************************************
  localparam int CMD_PLL_HI = 7;
  localparam int CMD_PLL_LO = 4;
  localparam int CMD_PHASE_HI = 3;
  localparam int CMD_PHASE_LO = 0;
  localparam logic [3:0] PLL_CMD   = 4'h5;
  localparam logic [3:0] PHASE_CMD = 4'hA;

endpackage

// ---- hw/pixel_pll_control_regs.sv ----
// Purpose: Low register bank of the pixel PLL and phase-adjust logic
// Assumes: Same-clock register port, read data one cycle after strobe
// Notes:   Double-buffered registers drive outputs from working copies
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

module pixel_pll_control_regs (
  input  wire logic                                 sys_clk_in,
  input  wire logic                                 rst_n_in,
  input  wire logic [pixel_pll_regs_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [pixel_pll_regs_pkg::DATA_W-1:0] wr_data_in,
  input  wire logic                                 wr_en_in,
  input  wire logic                                 rd_en_in,
  output logic      [pixel_pll_regs_pkg::DATA_W-1:0] rd_data_out,
  output logic      [1:0]                           schmitt_select_out,
  output logic                                      input_source_select_out,
  output logic                                      divider_load_select_out,
  output logic                                      feedback_polarity_out,
  output logic                                      reference_polarity_out,
  output logic                                      display_enable_polarity_out,
  output logic                                      detector_enable_out,
  output logic      [1:0]                           post_scaler_divider_out,
  output logic      [2:0]                           detector_gain_out,
  output logic      [11:0]                          feedback_divider_out,
  output logic      [5:0]                           phase_adjust_offset_out,
  output logic      [1:0]                           phase_adjust_resolution_out,
  output logic                                      converter_in_clock_enable_out,
  output logic                                      converter_clock_out_enable_out,
  output logic                                      delayed_sync_out_enable_out,
  output logic                                      function_source_select_out,
  output logic                                      function_delay_select_out,
  output logic      [7:0]                           oscillator_divider_value_out,
  output logic                                      shunt_cap_select_out,
  output logic      [2:0]                           filter_resistor_select_out,
  output logic      [2:0]                           filter_cap_select_out,
  output logic                                      filter_type_select_out,
  output logic                                      pll_reset_out,
  output logic                                      phase_adjust_reset_out
);
  import pixel_pll_regs_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [DATA_W-1:0] bank_reg [NUM_RW];
  logic [DATA_W-1:0] loop_work_reg;
  logic [DATA_W-1:0] fdiv_low_work_reg;
  logic [DATA_W-1:0] fdiv_high_work_reg;
  logic [DATA_W-1:0] phase_ctrl_work_reg;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic              pll_reset_reg;
  logic              phase_reset_reg;

  // ****************************************
  // Write decode
  // ****************************************
  logic [NUM_RW-1:0] wr_hit;
  logic              cmd_wr;
  logic              pll_cmd;
  logic              phase_cmd;
  logic              rd_mapped;

  // One select line per storage register
  for (genvar i = 0; i < NUM_RW; i++) begin : g_hit
    assign wr_hit[i] = wr_en_in && (addr_in == ADDR_W'(i));
  end

  // Reset command nibble decode
  assign cmd_wr    = wr_en_in && (addr_in == IDX_RESET_CMD);
  assign pll_cmd   = cmd_wr &&
                     (wr_data_in[CMD_PLL_HI:CMD_PLL_LO] == PLL_CMD);
  assign phase_cmd = cmd_wr &&
                     (wr_data_in[CMD_PHASE_HI:CMD_PHASE_LO] == PHASE_CMD);

  // ****************************************
  // Read path
  // ****************************************

  // Unmapped, reserved and write-only indices read zero
  assign rd_mapped    = addr_in < ADDR_W'(NUM_RW);
  assign rd_data_next = !rd_en_in  ? '0 :
                        !rd_mapped ? '0 :
                        bank_reg[addr_in];

  // Read data stands for one cycle only
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ****************************************
  // Holding and direct registers
  // ****************************************

  // Reserved bits masked off on write
  for (genvar i = 0; i < NUM_RW; i++) begin : g_bank
    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        bank_reg[i] <= RESET_VALS[i];
      end else if (wr_hit[i]) begin
        bank_reg[i] <= wr_data_in & WRITE_MASKS[i];
      end
    end
  end

  // ****************************************
  // Working copies
  // ****************************************

  // Pixel PLL working copies, loaded only by the PLL command
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      loop_work_reg      <= RESET_VALS[IDX_LOOP_CONTROL];
      fdiv_low_work_reg  <= RESET_VALS[IDX_FDIV_LOW];
      fdiv_high_work_reg <= RESET_VALS[IDX_FDIV_HIGH];
    end else if (pll_cmd) begin
      loop_work_reg      <= bank_reg[IDX_LOOP_CONTROL];
      fdiv_low_work_reg  <= bank_reg[IDX_FDIV_LOW];
      fdiv_high_work_reg <= bank_reg[IDX_FDIV_HIGH];
    end
  end

  // Phase-adjust working copy, loaded only by the phase command
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      phase_ctrl_work_reg <= RESET_VALS[IDX_PHASE_CONTROL];
    end else if (phase_cmd) begin
      phase_ctrl_work_reg <= bank_reg[IDX_PHASE_CONTROL];
    end
  end

  // Reset pulses, one cycle per accepted command
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      pll_reset_reg   <= 1'b0;
      phase_reset_reg <= 1'b0;
    end else begin
      pll_reset_reg   <= pll_cmd;
      phase_reset_reg <= phase_cmd;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Register port
  assign rd_data_out = rd_data_reg;

  // Input control fields
  assign schmitt_select_out =
    bank_reg[IDX_INPUT_CONTROL][SCHMITT_HI:SCHMITT_LO];
  assign input_source_select_out =
    bank_reg[IDX_INPUT_CONTROL][SRC_SEL_BIT];
  assign divider_load_select_out =
    bank_reg[IDX_INPUT_CONTROL][LOAD_SEL_BIT];
  assign feedback_polarity_out =
    bank_reg[IDX_INPUT_CONTROL][FB_POL_BIT];
  assign reference_polarity_out =
    bank_reg[IDX_INPUT_CONTROL][REF_POL_BIT];
  assign display_enable_polarity_out =
    bank_reg[IDX_INPUT_CONTROL][DE_POL_BIT];
  assign detector_enable_out =
    bank_reg[IDX_INPUT_CONTROL][DET_EN_BIT];

  // Pixel PLL fields from working copies
  assign post_scaler_divider_out = loop_work_reg[POST_SCALE_HI:POST_SCALE_LO];
  assign detector_gain_out       = loop_work_reg[GAIN_HI:GAIN_LO];
  assign feedback_divider_out    =
    {fdiv_high_work_reg[FDIV_HI_HI:0], fdiv_low_work_reg};

  // Phase-adjust fields
  assign phase_adjust_offset_out =
    bank_reg[IDX_PHASE_OFFSET][OFFSET_HI:0];
  assign phase_adjust_resolution_out =
    phase_ctrl_work_reg[RES_HI:0];

  // Output enables and function select
  assign converter_in_clock_enable_out =
    bank_reg[IDX_OUTPUT_ENABLES][TCK_OE_BIT];
  assign converter_clock_out_enable_out =
    bank_reg[IDX_OUTPUT_ENABLES][RCLK_OE_BIT];
  assign delayed_sync_out_enable_out =
    bank_reg[IDX_OUTPUT_ENABLES][SYNC_OE_BIT];
  assign function_source_select_out =
    bank_reg[IDX_OUTPUT_ENABLES][FUNC_SRC_BIT];
  assign function_delay_select_out =
    bank_reg[IDX_OUTPUT_ENABLES][FUNC_DLY_BIT];

  // Oscillator divider
  assign oscillator_divider_value_out = bank_reg[IDX_OSCILLATOR];

  // Internal loop filter
  assign shunt_cap_select_out =
    bank_reg[IDX_INT_FILTER][SHUNT_BIT];
  assign filter_resistor_select_out =
    bank_reg[IDX_INT_FILTER][RESIST_HI:RESIST_LO];
  assign filter_cap_select_out =
    bank_reg[IDX_INT_FILTER][CAP_HI:CAP_LO];
  assign filter_type_select_out =
    bank_reg[IDX_INT_FILTER][FILT_TYPE_BIT];

  // Command pulses
  assign pll_reset_out          = pll_reset_reg;
  assign phase_adjust_reset_out = phase_reset_reg;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Command writes
  sequence s_pll_cmd;
    wr_en_in && (addr_in == IDX_RESET_CMD) &&
    (wr_data_in[CMD_PLL_HI:CMD_PLL_LO] == PLL_CMD);
  endsequence

  sequence s_phase_cmd;
    wr_en_in && (addr_in == IDX_RESET_CMD) &&
    (wr_data_in[CMD_PHASE_HI:CMD_PHASE_LO] == PHASE_CMD);
  endsequence

  sequence s_pll_buffered_wr;
    wr_en_in && (addr_in >= IDX_LOOP_CONTROL) &&
    (addr_in <= IDX_FDIV_HIGH);
  endsequence

  // PLL command loads the divider and pulses reset
  property p_pll_load;
    s_pll_cmd |=> pll_reset_out &&
      (feedback_divider_out == {$past(bank_reg[IDX_FDIV_HIGH][FDIV_HI_HI:0]),
                                $past(bank_reg[IDX_FDIV_LOW])}) &&
      (detector_gain_out == $past(bank_reg[IDX_LOOP_CONTROL][GAIN_HI:GAIN_LO]));
  endproperty
  a_pll_load: assert property (p_pll_load)
    else $error("pll command did not load working copies");

  // Buffered writes leave the working copies alone
  property p_pll_hold;
    s_pll_buffered_wr ##1 !pll_reset_out |->
      $stable(feedback_divider_out) && $stable(post_scaler_divider_out);
  endproperty
  a_pll_hold: assert property (p_pll_hold)
    else $error("pll working copy changed without command");

  // Other upper nibbles do nothing to the PLL
  property p_no_pll;
    (cmd_wr && (wr_data_in[CMD_PLL_HI:CMD_PLL_LO] != PLL_CMD)) |=>
      !pll_reset_out && $stable(feedback_divider_out);
  endproperty
  a_no_pll: assert property (p_no_pll)
    else $error("pll state changed on other nibble");

  // Phase command loads resolution and pulses reset
  property p_phase_load;
    s_phase_cmd |=> phase_adjust_reset_out &&
      (phase_adjust_resolution_out ==
       $past(bank_reg[IDX_PHASE_CONTROL][RES_HI:0]));
  endproperty
  a_phase_load: assert property (p_phase_load)
    else $error("phase command did not load resolution");

  // Resolution never moves without the phase pulse
  property p_phase_hold;
    !phase_adjust_reset_out |-> $stable(phase_adjust_resolution_out);
  endproperty
  a_phase_hold: assert property (p_phase_hold)
    else $error("resolution changed without phase command");

  // PLL pulse only follows a matching command
  property p_pulse_cause;
    pll_reset_out |-> $past(pll_cmd) ##1 (!pll_reset_out || $past(pll_cmd));
  endproperty
  a_pulse_cause: assert property (p_pulse_cause)
    else $error("pll pulse without command");

  // Reserved and write-only indices read zero
  property p_rsvd_read;
    (rd_en_in && (addr_in >= ADDR_W'(NUM_RW))) |=> (rd_data_out == '0);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved index read nonzero");

  // Readback of input control one cycle later
  property p_read_back;
    (rd_en_in && (addr_in == IDX_INPUT_CONTROL)) |=>
      (rd_data_out == $past(bank_reg[IDX_INPUT_CONTROL])) ##1
      (rd_en_in || (rd_data_out == '0) || $past(rd_en_in));
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("input control readback wrong");

  // Reset values visible at the first edge after release
  property p_reset_vals;
    $rose(rst_n_in) |-> detector_enable_out && input_source_select_out &&
      (feedback_divider_out ==
       {RESET_VALS[IDX_FDIV_HIGH][FDIV_HI_HI:0], RESET_VALS[IDX_FDIV_LOW]}) &&
      (filter_cap_select_out == RESET_VALS[IDX_INT_FILTER][CAP_HI:CAP_LO]);
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset values wrong");

  // Phase offset applies directly
  property p_offset_direct;
    (wr_en_in && (addr_in == IDX_PHASE_OFFSET)) |=>
      (phase_adjust_offset_out == $past(wr_data_in[OFFSET_HI:0]));
  endproperty
  a_offset_direct: assert property (p_offset_direct)
    else $error("phase offset not applied");

  // Other lower nibbles do nothing to phase adjust
  property p_no_phase;
    (cmd_wr && (wr_data_in[CMD_PHASE_HI:CMD_PHASE_LO] != PHASE_CMD)) |=>
      !phase_adjust_reset_out && $stable(phase_adjust_resolution_out);
  endproperty
  a_no_phase: assert property (p_no_phase)
    else $error("phase state changed on other nibble");

  // Phase pulse only follows a matching command
  property p_phase_cause;
    phase_adjust_reset_out |-> $past(phase_cmd);
  endproperty
  a_phase_cause: assert property (p_phase_cause)
    else $error("phase pulse without command");

  // Read data falls back to zero without a read
  property p_rd_idle;
    !rd_en_in |=> (rd_data_out == '0);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data stood without a read");

  // Output enables and function selects apply directly
  property p_enables_direct;
    (wr_en_in && (addr_in == IDX_OUTPUT_ENABLES)) |=>
      ({converter_in_clock_enable_out, converter_clock_out_enable_out,
        delayed_sync_out_enable_out, function_source_select_out,
        function_delay_select_out} == $past(wr_data_in[TCK_OE_BIT:FUNC_DLY_BIT]));
  endproperty
  a_enables_direct: assert property (p_enables_direct)
    else $error("output enables not applied");

  // Oscillator divider applies directly
  property p_oscillator_direct;
    (wr_en_in && (addr_in == IDX_OSCILLATOR)) |=>
      (oscillator_divider_value_out == $past(wr_data_in));
  endproperty
  a_oscillator_direct: assert property (p_oscillator_direct)
    else $error("oscillator divider not applied");

  // Loop filter fields apply directly
  property p_filter_direct;
    (wr_en_in && (addr_in == IDX_INT_FILTER)) |=>
      ({shunt_cap_select_out, filter_resistor_select_out, filter_cap_select_out,
        filter_type_select_out} == $past(wr_data_in));
  endproperty
  a_filter_direct: assert property (p_filter_direct)
    else $error("loop filter fields not applied");

endmodule

// ---- tb/host_model.sv ----
// Purpose: Host side that programs the pixel PLL register bank
// Assumes: Every task is entered just after a rising clock edge
// Notes:   Reserved bits go out at their zero default unless raw is set
`timescale 1ns/1ps
module host_model (
  input  wire logic                                  sys_clk_in,
  input  wire logic [pixel_pll_regs_pkg::DATA_W-1:0] rd_data_in,
  output logic      [pixel_pll_regs_pkg::ADDR_W-1:0] addr_out,
  output logic      [pixel_pll_regs_pkg::DATA_W-1:0] wr_data_out,
  output logic                                       wr_en_out,
  output logic                                       rd_en_out
);
  import pixel_pll_regs_pkg::*;

  // ****************************************
  // Bus idle from time zero
  // ****************************************
  initial begin
    addr_out = 4'h0;
    wr_data_out = 8'h00;
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
  end

  // Bits the host may change at each index
  function automatic logic [7:0] legal_bits(input logic [3:0] a);
    case (a)
      4'h0, 4'h2, 4'h7, 4'h8, 4'hA: return 8'hFF;
      4'h1:    return 8'h37;
      4'h3:    return 8'h0F;
      4'h4:    return 8'h3F;
      4'h5:    return 8'h03;
      4'h6:    return 8'h7C;
      default: return 8'h00;
    endcase
  endfunction

  // ****************************************
  // Bus cycles
  // ****************************************
  // One-cycle write; strobe left up for a back-to-back follower
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit raw = 1'b0);
    addr_out <= a;
    wr_data_out <= raw ? d : (d & legal_bits(a));
    rd_en_out <= 1'b0;
    wr_en_out <= 1'b1;
    @(posedge sys_clk_in);
  endtask

  // One-cycle read; data taken at the edge closing the answer cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_out <= a;
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b1;
    @(posedge sys_clk_in);
    rd_en_out <= 1'b0;
    @(posedge sys_clk_in);
    d = rd_data_in;
  endtask

  // Drop both strobes for one cycle
  task automatic idle;
    wr_en_out <= 1'b0;
    rd_en_out <= 1'b0;
    @(posedge sys_clk_in);
  endtask
endmodule

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the pixel PLL register bank
// Assumes: 40 MHz clock, synchronous active-low reset
// Notes:   Outputs are sampled 1 ns after an edge, or at the edge that closes an idle or read cycle
`timescale 1ns/1ps
module tb;
  import pixel_pll_regs_pkg::*;

  logic              sys_clk_in = 1'b0;
  logic              rst_n_in = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic              wr_en;
  logic              rd_en;
  logic [DATA_W-1:0] rd_data;
  logic [1:0]        sch, pscl, res;
  logic [2:0]        gain, rsel, csel;
  logic [11:0]       fdiv;
  logic [5:0]        offs;
  logic [7:0]        osc;
  logic              src, lds, fbp, rfp, dep, den, tck, rck, syn, fsr, fdl;
  logic              shn, fty, pll_p, ph_p;
  int                err_count = 0;
  int                n_tests = 0;

  // ****************************************
  // Observed register images
  // ****************************************
  wire logic [7:0] obs00 = {sch, src, lds, fbp, rfp, dep, den};
  wire logic [7:0] obs01 = {2'b00, pscl, 1'b0, gain};
  wire logic [7:0] obs06 = {1'b0, tck, rck, syn, fsr, fdl, 2'b00};
  wire logic [7:0] obs08 = {shn, rsel, csel, fty};

  // Clock at 25 ns period
  always #12.5 sys_clk_in = ~sys_clk_in;

  host_model host (.sys_clk_in(sys_clk_in), .rd_data_in(rd_data), .addr_out(addr),
    .wr_data_out(wr_data), .wr_en_out(wr_en), .rd_en_out(rd_en));

  pixel_pll_control_regs uut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr),
    .wr_data_in(wr_data), .wr_en_in(wr_en), .rd_en_in(rd_en), .rd_data_out(rd_data),
    .schmitt_select_out(sch), .input_source_select_out(src), .divider_load_select_out(lds),
    .feedback_polarity_out(fbp), .reference_polarity_out(rfp),
    .display_enable_polarity_out(dep), .detector_enable_out(den),
    .post_scaler_divider_out(pscl), .detector_gain_out(gain), .feedback_divider_out(fdiv),
    .phase_adjust_offset_out(offs), .phase_adjust_resolution_out(res),
    .converter_in_clock_enable_out(tck), .converter_clock_out_enable_out(rck),
    .delayed_sync_out_enable_out(syn), .function_source_select_out(fsr),
    .function_delay_select_out(fdl), .oscillator_divider_value_out(osc),
    .shunt_cap_select_out(shn), .filter_resistor_select_out(rsel),
    .filter_cap_select_out(csel), .filter_type_select_out(fty),
    .pll_reset_out(pll_p), .phase_adjust_reset_out(ph_p));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [7:0] reset_val(input int a);
    case (a)
      0:       return 8'h21;
      2, 8:    return 8'hFF;
      default: return 8'h00;
    endcase
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values;
    logic [7:0] d;
    #1;
    chk(obs00, 12'h021);
    chk({obs01, res}, 12'h000);
    chk(fdiv, 12'h0FF);
    chk(offs, 12'h000);
    chk(obs06, 12'h000);
    chk(osc, 12'h000);
    chk(obs08, 12'h0FF);
    chk({pll_p, ph_p}, 12'h000);
    for (int a = 0; a < 16; a++) begin
      host.rd(a[3:0], d);
      chk(d, reset_val(a));
    end
    #1 chk(rd_data, 12'h000);
    $display("reset values done");
  endtask

  task automatic t_direct;
    logic [7:0] d, m;
    logic [7:0] v [5];
    logic [3:0] ad [5] = '{4'h0, 4'h4, 4'h6, 4'h7, 4'h8};
    logic [7:0] pt [5] = '{8'hDE, 8'h2A, 8'h6C, 8'hA5, 8'h36};
    for (int p = 0; p < 2; p++) begin
      // Eight-bit patterns, so the inversion stays inside bit 7
      for (int i = 0; i < 5; i++) v[i] = p ? ~pt[i] : pt[i];
      for (int i = 0; i < 5; i++) host.wr(ad[i], v[i]);
      host.idle;
      chk(obs00, v[0]);
      chk(offs, v[1] & 8'h3F);
      chk(obs06, v[2] & 8'h7C);
      chk(osc, v[3]);
      chk(obs08, v[4]);
      for (int i = 0; i < 5; i++) begin
        m = host.legal_bits(ad[i]);
        host.rd(ad[i], d);
        chk(d, v[i] & m);
      end
    end
    $display("direct registers done");
  endtask

  task automatic t_pll_buffer;
    logic [7:0] d;
    host.wr(4'h1, 8'h37);
    host.wr(4'h2, 8'h34);
    host.wr(4'h3, 8'h0C);
    host.wr(4'hA, 8'h4A);
    #1 chk({pll_p, ph_p}, 12'h001);
    chk({obs01, 4'h0}, 12'h000);
    chk(fdiv, 12'h0FF);
    host.wr(4'hA, 8'h50);
    #1 chk({pll_p, ph_p}, 12'h002);
    chk(obs01, 12'h037);
    chk(fdiv, 12'hC34);
    host.idle;
    #1 chk(pll_p, 12'h000);
    host.rd(4'h3, d);
    chk(d, 12'h00C);
    $display("pll buffering done");
  endtask

  task automatic t_phase;
    host.wr(4'h4, 8'h15);
    host.wr(4'h5, 8'h03);
    #1 chk(res, 12'h000);
    chk(offs, 12'h015);
    host.wr(4'hA, 8'h0A);
    #1 chk({pll_p, ph_p, res}, 12'h007);
    host.wr(4'h5, 8'h02);
    host.wr(4'h1, 8'h12);
    host.wr(4'hA, 8'h5A);
    #1 chk({pll_p, ph_p, res}, 12'h00E);
    chk(obs01, 12'h012);
    host.wr(4'h5, 8'h01);
    host.wr(4'h1, 8'h25);
    host.wr(4'hA, 8'h3B);
    #1 chk({pll_p, ph_p, res}, 12'h002);
    chk(obs01, 12'h012);
    host.idle;
    $display("phase adjust done");
  endtask

  task automatic t_reserved;
    logic [7:0] d;
    for (int a = 0; a < 16; a++) if (a != 10) host.wr(a[3:0], 8'hFF, 1'b1);
    for (int a = 0; a < 16; a++) begin
      host.rd(a[3:0], d);
      chk(d, (a < 9) ? host.legal_bits(a[3:0]) : 8'h00);
      chk({pll_p, ph_p}, 12'h000);
    end
    $display("reserved bits done");
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset_values;
    t_direct;
    t_pll_buffer;
    t_phase;
    t_reserved;
    @(posedge sys_clk_in);
    rst_n_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    t_reset_values;
    close_out;
  end

  initial begin
    repeat (3000) @(posedge sys_clk_in);
    err_count++;
    close_out;
  end
endmodule
